// ---- rtl/data_move_consts.vh ----
`ifndef DATA_MOVE_CONSTS_VH
`define DATA_MOVE_CONSTS_VH

// ****************************************
// Encoding fields of the 14-bit word
// ****************************************
`define INSTR_W          14
`define OPC_NO_OP        14'h0000
`define OPC_OPTION       14'h0062
`define OPC_BANK_MASK    14'h3FE0
`define OPC_BANK         14'h0020
`define OPC_PAGE_MASK    14'h3F80
`define OPC_PAGE         14'h3180
`define OPC_WORK_MASK    14'h3F00
`define OPC_WORK         14'h3000
`define OPC_FILE_MASK    14'h3F80
`define OPC_FILE         14'h0080
`define OPC_WI_MASK      14'h3FF8
`define OPC_WI           14'h0018
`define OPC_WIK_MASK     14'h3F80
`define OPC_WIK          14'h3F80

// ****************************************
// Field positions
// ****************************************
`define BANK_K_HI        4
`define PAGE_K_HI        6
`define WORK_K_HI        7
`define FILE_A_HI        6
`define PTR_SEL_BIT      2
`define MODE_HI          1
`define WIK_SEL_BIT      6
`define WIK_K_HI         5

// ****************************************
// Pointer update modes
// ****************************************
`define MODE_PREINC      2'b00
`define MODE_PREDEC      2'b01
`define MODE_POSTINC     2'b10
`define MODE_POSTDEC     2'b11

// ****************************************
// Reset values
// ****************************************
`define RST_WORK         8'h00
`define RST_BANK         5'h00
`define RST_PAGE         7'h00
`define RST_OPTION       8'hFF
`define RST_PTR          16'h0000

`endif

// ---- rtl/pointer_step.v ----
`timescale 1ns/1ps
`include "data_move_consts.vh"

// ****************************************
// Effective address and next pointer value
// ****************************************
module pointer_step #(
  parameter PTR_W = 16
) (
  input  wire [PTR_W-1:0] ptr_i,
  input  wire             indexed_i,
  input  wire [1:0]       mode_i,
  input  wire [5:0]       offset_i,
  output reg  [PTR_W-1:0] addr_o,
  output reg  [PTR_W-1:0] next_ptr_o
);
  wire [PTR_W-1:0] one;
  wire [PTR_W-1:0] k_ext;
  wire [PTR_W-1:0] inc;
  wire [PTR_W-1:0] dec;

  assign one   = {{(PTR_W-1){1'b0}}, 1'b1};
  assign k_ext = {{(PTR_W-6){offset_i[5]}}, offset_i};
  // Modular arithmetic wraps at both ends
  assign inc   = ptr_i + one;
  assign dec   = ptr_i - one;

  always @* begin
    addr_o     = ptr_i;
    next_ptr_o = ptr_i;
    if (indexed_i) begin
      addr_o = ptr_i + k_ext;
    end else begin
      case (mode_i)
        `MODE_PREINC: begin
          addr_o     = inc;
          next_ptr_o = inc;
        end
        `MODE_PREDEC: begin
          addr_o     = dec;
          next_ptr_o = dec;
        end
        `MODE_POSTINC: next_ptr_o = inc;
        `MODE_POSTDEC: next_ptr_o = dec;
        default: next_ptr_o = ptr_i;
      endcase
    end
  end
endmodule // pointer_step

// ---- rtl/move_decode.v ----
`timescale 1ns/1ps
`include "data_move_consts.vh"

// ****************************************
// Instruction class decode
// ****************************************
module move_decode (
  input  wire [`INSTR_W-1:0] instr_i,
  output wire                is_nop_o,
  output wire                is_option_o,
  output wire                is_bank_o,
  output wire                is_page_o,
  output wire                is_work_o,
  output wire                is_file_o,
  output wire                is_ind_o,
  output wire                is_ind_k_o
);
  assign is_nop_o    = instr_i == `OPC_NO_OP;
  assign is_option_o = instr_i == `OPC_OPTION;
  assign is_bank_o   = (instr_i & `OPC_BANK_MASK) == `OPC_BANK;
  assign is_page_o   = (instr_i & `OPC_PAGE_MASK) == `OPC_PAGE;
  assign is_work_o   = (instr_i & `OPC_WORK_MASK) == `OPC_WORK;
  assign is_file_o   = (instr_i & `OPC_FILE_MASK) == `OPC_FILE;
  assign is_ind_o    = (instr_i & `OPC_WI_MASK) == `OPC_WI;
  assign is_ind_k_o  = (instr_i & `OPC_WIK_MASK) == `OPC_WIK;
endmodule // move_decode

// ---- rtl/data_move_instruction_exec.v ----
`timescale 1ns/1ps
`include "data_move_consts.vh"

// Function
// - Bank literal load writes bank select from 5-bit field, flags kept.
// - Page literal load writes 7-bit literal into pc high latch.
// - Work literal load writes 8-bit literal into working register.
// - Store work to file writes working register to 7-bit address.
// - Indirect store writes working register via pointer 0 or 1.
// - Address is pointer+1, pointer-1, pointer (post modes), or pointer plus signed offset.
// - Mode 00 preinc, 01 predec, 10 postinc, 11 postdec; indexed keeps.
// - Pointer wraps around at both ends of its range.
// - Pointer updates and indirect stores change no status flag.
// - Indirect window accesses redirect to address in its pointer.
// - Option instruction copies working register to option register.
module data_move_instruction_exec #(
  parameter PTR_W      = 16,
  parameter IND0_ADDR  = 7'h00,
  parameter IND1_ADDR  = 7'h01
) (
  input  wire                ref_clk_i,
  input  wire                reset_i,
  input  wire                instr_valid_i,
  input  wire [`INSTR_W-1:0] instr_i,
  output reg  [7:0]          work_reg_o,
  output reg  [4:0]          bank_select_reg_o,
  output reg  [6:0]          pc_high_latch_o,
  output reg  [7:0]          option_reg_o,
  output reg  [PTR_W-1:0]    file_pointer0_o,
  output reg  [PTR_W-1:0]    file_pointer1_o,
  output reg                 mem_we_o,
  output reg                 mem_indirect_o,
  output reg  [PTR_W-1:0]    mem_addr_o,
  output reg  [7:0]          mem_wdata_o,
  output reg                 status_we_o,
  output reg                 done_o
);

  // ****************************************
  // Decode
  // ****************************************
  wire is_nop;
  wire is_option;
  wire is_bank;
  wire is_page;
  wire is_work;
  wire is_file;
  wire is_ind;
  wire is_ind_k;

  move_decode u_dec (
    .instr_i     (instr_i),
    .is_nop_o    (is_nop),
    .is_option_o (is_option),
    .is_bank_o   (is_bank),
    .is_page_o   (is_page),
    .is_work_o   (is_work),
    .is_file_o   (is_file),
    .is_ind_o    (is_ind),
    .is_ind_k_o  (is_ind_k)
  );

  // ****************************************
  // Pointer arithmetic
  // ****************************************
  wire             sel;
  wire [PTR_W-1:0] cur_ptr;
  wire [PTR_W-1:0] ind_addr;
  wire [PTR_W-1:0] next_ptr;
  wire [6:0]       file_addr;
  wire             file_is_win0;
  wire             file_is_win1;

  // Operand n picks which pointer serves the store
  assign sel = is_ind_k ? instr_i[`WIK_SEL_BIT]
                        : instr_i[`PTR_SEL_BIT];
  assign cur_ptr = sel ? file_pointer1_o : file_pointer0_o;

  pointer_step #(
    .PTR_W (PTR_W)
  ) u_step (
    .ptr_i      (cur_ptr),
    .indexed_i  (is_ind_k),
    .mode_i     (instr_i[`MODE_HI:0]),
    .offset_i   (instr_i[`WIK_K_HI:0]),
    .addr_o     (ind_addr),
    .next_ptr_o (next_ptr)
  );

  assign file_addr    = instr_i[`FILE_A_HI:0];
  assign file_is_win0 = file_addr == IND0_ADDR;
  assign file_is_win1 = file_addr == IND1_ADDR;

  // ****************************************
  // Execute, one instruction per cycle
  // ****************************************
  always @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      work_reg_o        <= `RST_WORK;
      bank_select_reg_o <= `RST_BANK;
      pc_high_latch_o   <= `RST_PAGE;
      option_reg_o      <= `RST_OPTION;
      file_pointer0_o   <= `RST_PTR;
      file_pointer1_o   <= `RST_PTR;
      mem_we_o          <= 1'b0;
      mem_indirect_o    <= 1'b0;
      mem_addr_o        <= `RST_PTR;
      mem_wdata_o       <= `RST_WORK;
      status_we_o       <= 1'b0;
      done_o            <= 1'b0;
    end else begin
      mem_we_o       <= 1'b0;
      mem_indirect_o <= 1'b0;
      // No instruction here touches status
      status_we_o    <= 1'b0;
      done_o         <= instr_valid_i;
      if (instr_valid_i) begin
        if (is_bank) begin
          bank_select_reg_o <= instr_i[`BANK_K_HI:0];
        end else if (is_page) begin
          pc_high_latch_o <= instr_i[`PAGE_K_HI:0];
        end else if (is_work) begin
          work_reg_o <= instr_i[`WORK_K_HI:0];
        end else if (is_file) begin
          mem_we_o    <= 1'b1;
          mem_wdata_o <= work_reg_o;
          if (file_is_win0) begin
            mem_indirect_o <= 1'b1;
            mem_addr_o     <= file_pointer0_o;
          end else if (file_is_win1) begin
            mem_indirect_o <= 1'b1;
            mem_addr_o     <= file_pointer1_o;
          end else begin
            mem_addr_o <= {{(PTR_W-7){1'b0}}, file_addr};
          end
        end else if (is_ind || is_ind_k) begin
          mem_we_o       <= 1'b1;
          mem_indirect_o <= 1'b1;
          mem_addr_o     <= ind_addr;
          mem_wdata_o    <= work_reg_o;
          if (sel) begin
            file_pointer1_o <= next_ptr;
          end else begin
            file_pointer0_o <= next_ptr;
          end
        end else if (is_option) begin
          option_reg_o <= work_reg_o;
        end
        // No-op and unknown words leave state alone
      end
    end
  end

endmodule // data_move_instruction_exec

// ---- tb/data_move_props.sv ----
`timescale 1ns/1ps
`include "data_move_consts.vh"
// ****************************************
// Port checker
// ****************************************
module data_move_props #(
  parameter PTR_W = 16
) (
  input wire                ref_clk_i,
  input wire                reset_i,
  input wire                instr_valid_i,
  input wire [`INSTR_W-1:0] instr_i,
  input wire [7:0]          work_reg_o,
  input wire [4:0]          bank_select_reg_o,
  input wire [6:0]          pc_high_latch_o,
  input wire [7:0]          option_reg_o,
  input wire [PTR_W-1:0]    file_pointer1_o,
  input wire                mem_we_o,
  input wire                mem_indirect_o,
  input wire [PTR_W-1:0]    mem_addr_o,
  input wire [7:0]          mem_wdata_o,
  input wire                status_we_o,
  input wire                done_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  wire v    = instr_valid_i;
  wire ld_w = v && (instr_i & `OPC_WORK_MASK) == `OPC_WORK;
  wire ld_b = v && (instr_i & `OPC_BANK_MASK) == `OPC_BANK;
  wire ld_p = v && (instr_i & `OPC_PAGE_MASK) == `OPC_PAGE;
  wire st_f = v && (instr_i & `OPC_FILE_MASK) == `OPC_FILE
              && instr_i[6:1] != 6'h00;
  wire st_i = v && (instr_i & `OPC_WI_MASK) == `OPC_WI && instr_i[2];
  wire st_o = v && instr_i == `OPC_OPTION;
  property p_work; ld_w |=> work_reg_o == $past(instr_i[7:0]); endproperty
  a_work: assert property (p_work) else $error("work load");
  property p_bank;
    ld_b |=> bank_select_reg_o == $past(instr_i[4:0]);
  endproperty
  a_bank: assert property (p_bank) else $error("bank load");
  property p_page;
    ld_p |=> pc_high_latch_o == $past(instr_i[6:0]);
  endproperty
  a_page: assert property (p_page) else $error("page load");
  property p_file;
    st_f |=> mem_we_o && !mem_indirect_o && mem_addr_o == $past(instr_i[6:0]);
  endproperty
  a_file: assert property (p_file) else $error("file store");
  property p_wdat; st_f || st_i |=> mem_wdata_o == $past(work_reg_o); endproperty
  a_wdat: assert property (p_wdat) else $error("store data");
  property p_pre;
    st_i && instr_i[1:0] == 2'b00 |=> mem_addr_o == $past(file_pointer1_o) + 1'b1;
  endproperty
  a_pre: assert property (p_pre) else $error("preinc address");
  property p_post;
    st_i && instr_i[1:0] == 2'b10 |=> mem_addr_o == $past(file_pointer1_o)
      && file_pointer1_o == $past(file_pointer1_o) + 1'b1;
  endproperty
  a_post: assert property (p_post) else $error("postinc update");
  property p_opt; st_o |=> option_reg_o == $past(work_reg_o); endproperty
  a_opt: assert property (p_opt) else $error("option copy");
  property p_done; v |=> done_o ##1 done_o == $past(v); endproperty
  a_done: assert property (p_done) else $error("done pulse");
  property p_stat; !status_we_o; endproperty
  a_stat: assert property (p_stat) else $error("status write");
  c_ind: cover property (st_i);
  c_file: cover property (st_f);
  c_opt: cover property (st_o);
endmodule // data_move_props
bind data_move_instruction_exec data_move_props #(.PTR_W(PTR_W)) props_i (.*);

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`include "data_move_consts.vh"
// ****************************************
// Bench
// ****************************************
module testbench;
  logic        ref_clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        instr_valid_i = 1'b0;
  logic [13:0] instr_i = 14'h0000;
  logic [7:0]  work_reg_o, option_reg_o, mem_wdata_o;
  logic [4:0]  bank_select_reg_o;
  logic [6:0]  pc_high_latch_o;
  logic [15:0] file_pointer0_o, file_pointer1_o, mem_addr_o;
  logic        mem_we_o, mem_indirect_o, status_we_o, done_o;
  int          n_fail = 0;
  int          comparisons = 0;
  int          cycles = 0;
  data_move_instruction_exec data_move_instruction_exec_i (.*);
  always #10 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_fail = n_fail + 1;
      summarize();
    end
  end
  task summarize;
    $display("comparisons %0d failures %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Valid stays high so back to back words never retoggle it
  task ex(input logic [13:0] w);
    instr_i = w;
    instr_valid_i = 1'b1;
    @(posedge ref_clk_i);
    #2;
  endtask
  task idle;
    instr_valid_i = 1'b0;
    @(posedge ref_clk_i);
    #2;
  endtask
  task t_lit;
    ex(`OPC_WORK | 14'h00FF);
    chk(work_reg_o, 16'h00FF);
    chk(done_o, 16'h0001);
    ex(`OPC_BANK | 14'h000F);
    chk(bank_select_reg_o, 16'h000F);
    ex(`OPC_PAGE | 14'h007F);
    chk(pc_high_latch_o, 16'h007F);
    chk(bank_select_reg_o, 16'h000F);
    ex(`OPC_NO_OP);
    chk(mem_we_o, 16'h0000);
    chk(work_reg_o, 16'h00FF);
    idle();
    chk(done_o, 16'h0000);
  endtask
  task t_file;
    ex(`OPC_WORK | 14'h004F);
    ex(`OPC_FILE | 14'h007F);
    chk(mem_we_o, 16'h0001);
    chk(mem_addr_o, 16'h007F);
    chk(mem_wdata_o, 16'h004F);
    ex(`OPC_OPTION);
    chk(option_reg_o, 16'h004F);
    chk(mem_we_o, 16'h0000);
    idle();
  endtask
  // Mode order 01,00,11,10 from zero crosses both ends of the range
  task t_ind;
    logic [15:0] p, a;
    logic [1:0]  m;
    int          i;
    p = 16'h0000;
    for (i = 0; i < 4; i++) begin
      m = i[1:0] ^ 2'b01;
      a = m == 2'b00 ? p + 16'h0001 : m == 2'b01 ? p - 16'h0001 : p;
      p = m[0] ? p - 16'h0001 : p + 16'h0001;
      ex(`OPC_WI | 14'h0004 | {12'h000, m});
      chk(mem_addr_o, a);
      chk(file_pointer1_o, p);
      chk(mem_we_o & mem_indirect_o, 16'h0001);
      chk(mem_wdata_o, 16'h004F);
      chk(status_we_o, 16'h0000);
    end
    ex(`OPC_WIK | 14'h0040 | 14'h0020);
    chk(mem_addr_o, p - 16'h0020);
    chk(file_pointer1_o, p);
    ex(`OPC_FILE | 14'h0001);
    chk(mem_addr_o, p);
    chk(mem_indirect_o, 16'h0001);
    chk(file_pointer0_o, 16'h0000);
    ex(`OPC_WI | 14'h0001);
    chk(mem_addr_o, 16'hFFFF);
    chk(file_pointer0_o, 16'hFFFF);
    chk(file_pointer1_o, p);
    ex(`OPC_FILE | 14'h0000);
    chk(mem_addr_o, 16'hFFFF);
    chk(mem_we_o & mem_indirect_o, 16'h0001);
    idle();
  endtask
  initial begin
    repeat (16) @(posedge ref_clk_i);
    #2;
    reset_i = 1'b0;
    t_lit();
    t_file();
    t_ind();
    summarize();
  end
endmodule // testbench
